/* bench/cp_xfer_sva.sv */
// Purpose: Link checks between the core end and the register end
// Assumes: ce drops only while the link is idle
// Notes: Reserved read bits are checked as zero, the chosen reading
`timescale 1ns/1ps
module cp_xfer_sva
  import cp_regs_pkg::*;
  (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link
  input wire logic req,
  input wire logic write,
  input wire logic [2:0] op1,
  input wire logic [3:0] crn,
  input wire logic [3:0] crm,
  input wire logic [2:0] op2,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic undef,
  input wire logic [DATA_W-1:0] rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic dbg_hit;
  logic map_hit;
  assign dbg_hit = op1 == OP1_DEBUG && crn == CRN_SYS && op2 == OP2_ZERO
    && (crm == CRM_CACHE || crm == CRM_TLB);
  assign map_hit = dbg_hit || (op1 == OP1_REMAP && crn == CRN_SYS
    && op2 == OP2_ZERO && crm == CRM_REMAP);
  sequence read_of(m);
    req && !write && map_hit && crm == m;
  endsequence
  sequence answered;
    ##1 ack;
  endsequence
  a_ack_one_edge: assert property (req |-> answered)
    else $error("ack missing after request");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_single: assert property (req |=> !req)
    else $error("request held past one cycle");
  a_unmapped_refused: assert property (req && !map_hit |=> ack && undef)
    else $error("unmapped encoding not refused");
  a_mapped_taken: assert property (req && map_hit |=> !undef)
    else $error("mapped encoding refused");
  a_unmapped_zero: assert property (req && !write && !map_hit |=> rdata == '0)
    else $error("unmapped read not zero");
  a_cache_rsv_zero: assert property (read_of(CRM_CACHE) |=> rdata[31:3] == '0)
    else $error("cache reserved bits not zero");
  a_tlb_rsv_zero: assert property (read_of(CRM_TLB) |=> rdata[31:8] == '0)
    else $error("tlb reserved bits not zero");
  a_remap_upper: assert property (read_of(CRM_REMAP) |=> rdata[31:16] == '0)
    else $error("remap upper bits not zero");
  a_rdata_holds: assert property ((!ack || $past(write)) |-> $stable(rdata))
    else $error("read data moved without read");
  a_wdata_masked: assert property (req && write && dbg_hit && crm == CRM_CACHE
    |-> wdata[31:3] == '0)
    else $error("reserved write bits not zero");
endmodule : cp_xfer_sva

/* bench/tb_cache_mmu_debug_remap_control.sv */
// Purpose: Drives commands at the core end, watches the register end
// Assumes: ce low only while idle; unmapped select 3 is refused
// Notes: Write answers carry no read data, so only the flag is compared
`timescale 1ns/1ps
module tb_cache_mmu_debug_remap_control
  import cp_regs_pkg::*;
  ;
  logic ref_clk, rst, ce, cmd_valid, cmd_ready, cmd_write, cmd_seal;
  logic resp_valid, resp_error, dc_write_hit, dc_line_dirty;
  reg_sel_e cmd_sel;
  logic [DATA_W-1:0] cmd_wdata, resp_rdata;
  attr_e inst_class, data_class, inst_attr, data_attr;
  logic dc_mark_dirty, dc_write_external, ic_alloc_en, dc_alloc_en;
  logic ic_miss_forward, dc_miss_forward, force_write_through;
  logic [3:0] fill_word_count;
  logic mi_l, md_l, mi_m, md_m, ui_m, ud_m, ui_l, ud_l;
  logic [TLB_W-1:0] tlb_debug_bits;
  logic [7:0] en_vec;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  logic [31:0] seed, r;
  int n_mismatch, cmp_count, c, i;
  assign en_vec = {mi_m, md_m, mi_l, md_l, ui_m, ud_m, ui_l, ud_l};
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  cp_xfer_if cp_xfer_if_inst (.ref_clk(ref_clk));
  cp_xfer_sva cp_xfer_sva_inst (.ref_clk(ref_clk), .rst(rst),
    .req(cp_xfer_if_inst.req), .write(cp_xfer_if_inst.write),
    .op1(cp_xfer_if_inst.op1), .crn(cp_xfer_if_inst.crn),
    .crm(cp_xfer_if_inst.crm), .op2(cp_xfer_if_inst.op2),
    .wdata(cp_xfer_if_inst.wdata), .ack(cp_xfer_if_inst.ack),
    .undef(cp_xfer_if_inst.undef), .rdata(cp_xfer_if_inst.rdata));
  cp_core_port cp_core_port_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_seal(cmd_seal), .cmd_wdata(cmd_wdata),
    .resp_valid(resp_valid), .resp_error(resp_error),
    .resp_rdata(resp_rdata), .bus(cp_xfer_if_inst));
  cache_mmu_debug_regs #(.FILL_WORDS(8)) cache_mmu_debug_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .bus(cp_xfer_if_inst),
    .inst_class(inst_class), .data_class(data_class),
    .inst_attr(inst_attr), .data_attr(data_attr),
    .dc_write_hit(dc_write_hit), .dc_line_dirty(dc_line_dirty),
    .dc_mark_dirty(dc_mark_dirty), .dc_write_external(dc_write_external),
    .ic_alloc_en(ic_alloc_en), .dc_alloc_en(dc_alloc_en),
    .ic_miss_forward(ic_miss_forward), .dc_miss_forward(dc_miss_forward),
    .fill_word_count(fill_word_count),
    .main_tlb_inst_load_en(mi_l), .main_tlb_data_load_en(md_l),
    .main_tlb_inst_match_en(mi_m), .main_tlb_data_match_en(md_m),
    .micro_tlb_inst_match_en(ui_m), .micro_tlb_data_match_en(ud_m),
    .micro_tlb_inst_load_en(ui_l), .micro_tlb_data_load_en(ud_l),
    .force_write_through(force_write_through),
    .tlb_debug_bits(tlb_debug_bits));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Note: {compare data, error flag, read data}
  task cmd(input logic w, input reg_sel_e s, input logic seal,
    input logic [31:0] d, input logic [33:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_sel <= s;
    cmd_seal <= seal;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (resp_valid !== 1'b1 && k < 20);
    if (resp_valid !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : cmd
  task set_in(input int a, input logic h, input logic dd);
    @(posedge ref_clk);
    inst_class <= attr_e'(a[1:0]);
    data_class <= attr_e'(a[1:0]);
    dc_write_hit <= h;
    dc_line_dirty <= dd;
    #1;
  endtask : set_in
  // Oldest note is matched to each answer
  always @(posedge ref_clk)
    if (resp_valid === 1'b1)
    begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
      chk({31'h0, resp_error}, {31'h0, note[32]});
      if (note[33])
        chk(resp_rdata, note[31:0]);
    end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = SEL_CACHE;
    cmd_seal = 1'b0;
    cmd_wdata = '0;
    inst_class = ATTR_NCNB;
    data_class = ATTR_NCNB;
    dc_write_hit = 1'b0;
    dc_line_dirty = 1'b0;
    seed = 32'h0000_DFBB;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    cmd(0, SEL_CACHE, 0, 0, 34'h2_0000_0000);
    cmd(0, SEL_TLB, 0, 0, 34'h2_0000_0000);
    cmd(0, SEL_REMAP, 0, 0, 34'h2_0000_E4E4);
    chk({24'h0, en_vec}, 32'hFF);
    for (c = 0; c < 4; c++)
    begin
      set_in(c, 0, 0);
      chk({inst_attr, data_attr}, {c[1:0], c[1:0]});
    end
    $display("test reset done");
    for (c = 3; c >= 0; c--)
    begin
      cmd(1, SEL_CACHE, 0, 32'hFFFF_FFF8 | c, 34'h0);
      cmd(0, SEL_CACHE, 0, 0, {2'b10, 32'(c)});
      chk({ic_alloc_en, dc_alloc_en, ic_miss_forward, dc_miss_forward},
        {~c[1], ~c[0], c[1], c[0]});
    end
    chk({28'h0, fill_word_count}, 32'h8);
    cmd(1, SEL_CACHE, 0, 32'h4, 34'h0);
    set_in(3, 1, 0);
    chk({data_attr, inst_attr}, {ATTR_WT, ATTR_WB});
    chk({dc_mark_dirty, dc_write_external}, 2'b01);
    set_in(3, 1, 1);
    chk({force_write_through, dc_mark_dirty, dc_write_external}, 3'b101);
    cmd(1, SEL_CACHE, 0, 32'h0, 34'h0);
    set_in(3, 1, 0);
    chk({data_attr, dc_mark_dirty, dc_write_external}, 4'b1110);
    $display("test cache done");
    for (c = 0; c < 8; c++)
    begin
      cmd(1, SEL_TLB, 0, 32'h1 << c, 34'h0);
      cmd(0, SEL_TLB, 0, 0, 34'h2_0000_0000 | (34'h1 << c));
      chk({en_vec, tlb_debug_bits}, {~(8'h1 << c), 8'h1 << c});
    end
    cmd(0, SEL_REMAP, 1, 0, 34'h2_0000_E4E4);
    chk({24'h0, tlb_debug_bits}, TLB_SEAL);
    $display("test tlb done");
    for (i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      r = seed;
      cmd(1, SEL_REMAP, 0, r, 34'h0);
      cmd(1, SEL_CACHE, 0, {29'h0, r[16], 2'b00}, 34'h0);
      cmd(0, SEL_REMAP, 0, 0, {18'h2_0000, r[15:0]});
      for (c = 0; c < 4; c++)
      begin
        set_in(c, 0, 0);
        chk(inst_attr, r[8 + 2 * c +: 2]);
        chk(data_attr, (r[16] && r[2 * c +: 2] == 2'b11) ? 2'b10
          : r[2 * c +: 2]);
      end
    end
    $display("test remap done");
    cmd(0, reg_sel_e'(2'b11), 0, 0, 34'h3_0000_0000);
    cmd(1, reg_sel_e'(2'b11), 0, 32'h0, 34'h1_0000_0000);
    cmd(0, SEL_REMAP, 0, 0, {18'h2_0000, r[15:0]});
    $display("test refuse done");
    // Enable low: a pending write must not land or be answered
    @(posedge ref_clk);
    ce <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_sel <= SEL_TLB;
    cmd_seal <= 1'b0;
    cmd_wdata <= 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({22'h0, resp_valid, cmd_ready, tlb_debug_bits}, 32'h13F);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    ce <= 1'b1;
    cmd(0, SEL_TLB, 0, 0, 34'h2_0000_003F);
    $display("test hold done");
    // Let the last answer reach the watcher before judging
    repeat (2) @(posedge ref_clk);
    chk(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule : tb_cache_mmu_debug_remap_control

/* logic/cache_mmu_debug_regs.sv */
// Purpose: Debug control and region remap registers with their effects
// Assumes: Caches and TLBs act on the enables and attributes given here
// Notes: Writes act from the cycle after the request edge
`timescale 1ns/1ps
module cache_mmu_debug_regs
  import cp_regs_pkg::*;
  #(
  parameter int FILL_WORDS = LINE_WORDS
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Transfer link
  cp_xfer_if.regs bus,
  // Attribute resolution
  input wire attr_e inst_class,
  input wire attr_e data_class,
  output attr_e inst_attr,
  output attr_e data_attr,
  // Data cache write hit handling
  input wire logic dc_write_hit,
  input wire logic dc_line_dirty,
  output logic dc_mark_dirty,
  output logic dc_write_external,
  // Linefill control
  output logic ic_alloc_en,
  output logic dc_alloc_en,
  output logic ic_miss_forward,
  output logic dc_miss_forward,
  output logic [3:0] fill_word_count,
  // TLB control
  output logic main_tlb_inst_load_en,
  output logic main_tlb_data_load_en,
  output logic main_tlb_inst_match_en,
  output logic main_tlb_data_match_en,
  output logic micro_tlb_inst_match_en,
  output logic micro_tlb_data_match_en,
  output logic micro_tlb_inst_load_en,
  output logic micro_tlb_data_load_en,
  // Register views
  output logic force_write_through,
  output logic [TLB_W-1:0] tlb_debug_bits
);

  if (FILL_WORDS < 1 || FILL_WORDS > 15)
    $error("FILL_WORDS out of range");

  logic [CACHE_W-1:0] cache_debug_control;
  logic [TLB_W-1:0] tlb_debug_control;
  logic [REMAP_W-1:0] region_attribute_remap;
  logic hit_cache;
  logic hit_tlb;
  logic hit_remap;
  logic [DATA_W-1:0] next_rdata;
  logic [REMAP_FIELD_W-1:0] inst_field;
  logic [REMAP_FIELD_W-1:0] data_field;
  logic inst_fill_off;
  logic data_fill_off;

  // Address decode
  always_comb
  begin
    hit_cache = bus.op1 == OP1_DEBUG && bus.crn == CRN_SYS
      && bus.crm == CRM_CACHE && bus.op2 == OP2_ZERO;
    hit_tlb = bus.op1 == OP1_DEBUG && bus.crn == CRN_SYS
      && bus.crm == CRM_TLB && bus.op2 == OP2_ZERO;
    hit_remap = bus.op1 == OP1_REMAP && bus.crn == CRN_SYS
      && bus.crm == CRM_REMAP && bus.op2 == OP2_ZERO;
  end

  // Cache debug register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cache_debug_control <= CACHE_RESET;
    else if (ce && bus.req && bus.write && hit_cache)
      cache_debug_control <= bus.wdata[CACHE_W-1:0];
  end

  // TLB debug register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      tlb_debug_control <= TLB_RESET;
    else if (ce && bus.req && bus.write && hit_tlb)
      tlb_debug_control <= bus.wdata[TLB_W-1:0];
  end

  // Remap register; upper half is not stored so it stays zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      region_attribute_remap <= REMAP_RESET;
    else if (ce && bus.req && bus.write && hit_remap)
      region_attribute_remap <= bus.wdata[REMAP_W-1:0];
  end

  // Read data; reserved bits answer zero
  always_comb
  begin
    next_rdata = '0;
    if (hit_cache)
      next_rdata = DATA_W'(cache_debug_control);
    else if (hit_tlb)
      next_rdata = DATA_W'(tlb_debug_control);
    else if (hit_remap)
      next_rdata = DATA_W'(region_attribute_remap);
  end

  // Answer one enabled cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus.ack <= 1'b0;
      bus.undef <= 1'b0;
      bus.rdata <= '0;
    end
    else if (ce)
    begin
      bus.ack <= bus.req;
      bus.undef <= bus.req && !(hit_cache || hit_tlb || hit_remap);
      if (bus.req && !bus.write)
        bus.rdata <= next_rdata;
    end
  end

  // Attribute resolution, remap applied to any incoming class
  always_comb
  begin
    inst_field = region_attribute_remap[REMAP_INST_LSB
      + REMAP_FIELD_W * int'(inst_class) +: REMAP_FIELD_W];
    data_field = region_attribute_remap[REMAP_DATA_LSB
      + REMAP_FIELD_W * int'(data_class) +: REMAP_FIELD_W];
    inst_attr = attr_e'(inst_field);
    data_attr = attr_e'(data_field);
    // Force is the last stage so remap cannot undo it
    if (force_write_through && data_attr == ATTR_WB)
      data_attr = ATTR_WT;
  end

  assign force_write_through = cache_debug_control[BIT_FORCE_WT];
  assign tlb_debug_bits = tlb_debug_control;

  // Write hit: clean lines stay clean unless data_attr is WB, dirty lines are never cleared here
  always_comb
  begin
    dc_mark_dirty = 1'b0;
    dc_write_external = 1'b0;
    if (dc_write_hit)
    begin
      if (data_attr == ATTR_WB)
        dc_mark_dirty = 1'b1;
      else
        dc_write_external = 1'b1;
      // Dirty line keeps its mark; other words still owed a write-back
      if (force_write_through && dc_line_dirty)
        dc_write_external = 1'b1;
    end
  end

  // Linefill: still fetch the full line, just do not allocate it
  assign inst_fill_off = cache_debug_control[BIT_INST_FILL_OFF];
  assign data_fill_off = cache_debug_control[BIT_DATA_FILL_OFF];
  assign ic_alloc_en = !inst_fill_off;
  assign dc_alloc_en = !data_fill_off;
  assign ic_miss_forward = inst_fill_off;
  assign dc_miss_forward = data_fill_off;
  assign fill_word_count = 4'(FILL_WORDS);

  // TLB enables; the walk itself is never stopped by these
  assign main_tlb_inst_load_en =
    !tlb_debug_control[BIT_MAIN_I_LOAD_OFF];
  assign main_tlb_data_load_en =
    !tlb_debug_control[BIT_MAIN_D_LOAD_OFF];
  assign main_tlb_inst_match_en =
    !tlb_debug_control[BIT_MAIN_I_MATCH_OFF];
  assign main_tlb_data_match_en =
    !tlb_debug_control[BIT_MAIN_D_MATCH_OFF];
  assign micro_tlb_inst_match_en =
    !tlb_debug_control[BIT_MICRO_I_MATCH_OFF];
  assign micro_tlb_data_match_en =
    !tlb_debug_control[BIT_MICRO_D_MATCH_OFF];
  assign micro_tlb_inst_load_en =
    !tlb_debug_control[BIT_MICRO_I_LOAD_OFF];
  assign micro_tlb_data_load_en =
    !tlb_debug_control[BIT_MICRO_D_LOAD_OFF];

endmodule : cache_mmu_debug_regs

/* logic/cp_core_port.sv */
// Purpose: Core side issuing register transfers to the debug registers
// Assumes: One command in flight; answer arrives on ack
// Notes: Optional seal write of the TLB debug bits precedes a command
`timescale 1ns/1ps
module cp_core_port
  import cp_regs_pkg::*;
  (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire reg_sel_e cmd_sel,
  input wire logic cmd_seal,
  input wire logic [DATA_W-1:0] cmd_wdata,
  // Response
  output logic resp_valid,
  output logic resp_error,
  output logic [DATA_W-1:0] resp_rdata,
  // Transfer link
  cp_xfer_if.core bus
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEAL = 2'b11,
    ST_CMD = 2'b01
  } state_e;

  state_e state;
  logic held_write;
  reg_sel_e held_sel;
  logic [DATA_W-1:0] held_wdata;

  assign cmd_ready = state == ST_IDLE;

  // Encoding of a selected register onto the link
  task automatic drive(input logic wr, input reg_sel_e sel,
                       input logic [DATA_W-1:0] data);
    bus.req <= 1'b1;
    bus.write <= wr;
    bus.crn <= CRN_SYS;
    bus.op2 <= OP2_ZERO;
    case (sel)
      SEL_CACHE:
      begin
        bus.op1 <= OP1_DEBUG;
        bus.crm <= CRM_CACHE;
        bus.wdata <= data & CACHE_WMASK;
      end
      SEL_TLB:
      begin
        bus.op1 <= OP1_DEBUG;
        bus.crm <= CRM_TLB;
        bus.wdata <= data & TLB_WMASK;
      end
      SEL_REMAP:
      begin
        bus.op1 <= OP1_REMAP;
        bus.crm <= CRM_REMAP;
        bus.wdata <= data & REMAP_WMASK;
      end
      default:
      begin
        // Spare select goes out unmapped so the far end refuses it
        bus.op1 <= OP1_REMAP;
        bus.crm <= CRM_TLB;
        bus.wdata <= '0;
      end
    endcase
  endtask : drive

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      held_write <= 1'b0;
      held_sel <= SEL_CACHE;
      held_wdata <= '0;
      bus.req <= 1'b0;
      bus.write <= 1'b0;
      bus.op1 <= OP1_REMAP;
      bus.crn <= CRN_SYS;
      bus.crm <= CRM_CACHE;
      bus.op2 <= OP2_ZERO;
      bus.wdata <= '0;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= '0;
    end
    else if (ce)
    begin
      bus.req <= 1'b0;
      resp_valid <= 1'b0;
      case (state)
        ST_IDLE:
          if (cmd_valid)
          begin
            held_write <= cmd_write;
            held_sel <= cmd_sel;
            held_wdata <= cmd_wdata;
            if (cmd_seal)
            begin
              // Freeze TLB contents before anything else moves
              drive(1'b1, SEL_TLB, TLB_SEAL);
              state <= ST_SEAL;
            end
            else
            begin
              drive(cmd_write, cmd_sel, cmd_wdata);
              state <= ST_CMD;
            end
          end
        ST_SEAL:
          if (bus.ack)
          begin
            drive(held_write, held_sel, held_wdata);
            state <= ST_CMD;
          end
        ST_CMD:
          if (bus.ack)
          begin
            resp_valid <= 1'b1;
            resp_error <= bus.undef;
            resp_rdata <= bus.rdata;
            state <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule : cp_core_port

/* logic/cp_regs_pkg.sv */
// Purpose: Shared encodings for the debug and remap register pair of ends
// Assumes: Transfers carry opcode1, primary, secondary and opcode2 fields
// Notes: Field positions and reset values live here only
package cp_regs_pkg;

  localparam int DATA_W = 32;

  // Transfer encoding
  localparam logic [2:0] OP1_DEBUG = 3'h7;
  localparam logic [2:0] OP1_REMAP = 3'h0;
  localparam logic [3:0] CRN_SYS = 4'hF;
  localparam logic [3:0] CRM_CACHE = 4'h0;
  localparam logic [3:0] CRM_TLB = 4'h1;
  localparam logic [3:0] CRM_REMAP = 4'h2;
  localparam logic [2:0] OP2_ZERO = 3'h0;

  // Stored widths
  localparam int CACHE_W = 3;
  localparam int TLB_W = 8;
  localparam int REMAP_W = 16;

  // Cache debug bit positions
  localparam int BIT_FORCE_WT = 2;
  localparam int BIT_INST_FILL_OFF = 1;
  localparam int BIT_DATA_FILL_OFF = 0;

  // TLB debug bit positions
  localparam int BIT_MAIN_I_MATCH_OFF = 7;
  localparam int BIT_MAIN_D_MATCH_OFF = 6;
  localparam int BIT_MAIN_I_LOAD_OFF = 5;
  localparam int BIT_MAIN_D_LOAD_OFF = 4;
  localparam int BIT_MICRO_I_MATCH_OFF = 3;
  localparam int BIT_MICRO_D_MATCH_OFF = 2;
  localparam int BIT_MICRO_I_LOAD_OFF = 1;
  localparam int BIT_MICRO_D_LOAD_OFF = 0;

  // Remap layout: side base plus two bits per class code
  localparam int REMAP_INST_LSB = 8;
  localparam int REMAP_DATA_LSB = 0;
  localparam int REMAP_FIELD_W = 2;

  // Reset values
  localparam logic [CACHE_W-1:0] CACHE_RESET = 3'h0;
  localparam logic [TLB_W-1:0] TLB_RESET = 8'h00;
  localparam logic [REMAP_W-1:0] REMAP_RESET = 16'hE4E4;

  // Writable masks; reserved bits go out as zero
  localparam logic [DATA_W-1:0] CACHE_WMASK = 32'h0000_0007;
  localparam logic [DATA_W-1:0] TLB_WMASK = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] REMAP_WMASK = 32'h0000_FFFF;

  // Value written before a command that has cmd_seal set
  localparam logic [DATA_W-1:0] TLB_SEAL = 32'h0000_003F;

  // Linefill length in words
  localparam int LINE_WORDS = 8;

  typedef enum logic [1:0] {
    ATTR_NCNB = 2'b00,
    ATTR_NCB = 2'b01,
    ATTR_WT = 2'b10,
    ATTR_WB = 2'b11
  } attr_e;

  typedef enum logic [1:0] {
    SEL_CACHE = 2'b00,
    SEL_TLB = 2'b01,
    SEL_REMAP = 2'b10
  } reg_sel_e;

endpackage : cp_regs_pkg

/* logic/cp_xfer_if.sv */
// Purpose: Coprocessor register transfer link between core and registers
// Assumes: One clock; request is a one-cycle pulse
// Notes: Answer follows one enabled cycle after the request
`timescale 1ns/1ps
interface cp_xfer_if
  import cp_regs_pkg::*;
  (
  input wire logic ref_clk
);
  logic req;
  logic write;
  logic [2:0] op1;
  logic [3:0] crn;
  logic [3:0] crm;
  logic [2:0] op2;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic undef;
  logic [DATA_W-1:0] rdata;

  modport core (
    output req, write, op1, crn, crm, op2, wdata,
    input ack, undef, rdata
  );

  modport regs (
    input req, write, op1, crn, crm, op2, wdata,
    output ack, undef, rdata
  );
endinterface : cp_xfer_if
